// ---- inc/bfc_defines.svh ----
`ifndef BFC_DEFINES_SVH
`define BFC_DEFINES_SVH
// ==========================================================
// register map
`define BFC_ADDR_W 12
`define BFC_CTRL_OFFS 12'h800
// ==========================================================
// field positions (position 0 is the lsb of the word)
`define BFC_PRES_BIT 31
`define BFC_ABS_BIT 30
`define BFC_ONEPUSH_BIT 26
`define BFC_ONOFF_BIT 25
`define BFC_AM_BIT 24
`define BFC_VAL_HI 11
`define BFC_VAL_LO 0
// ==========================================================
// reset values
`define BFC_ABS_RST 1'b0
`define BFC_AM_RST 1'b0
`define BFC_VAL_RST 12'h000
// ==========================================================
// timing: longest one-shot run, rounded down, at 4 ns per cycle
`define BFC_CLK_PERIOD_NS 4
`define BFC_ONESHOT_TIME_NS 2000
`define BFC_ONESHOT_CYC (`BFC_ONESHOT_TIME_NS / `BFC_CLK_PERIOD_NS)
`endif

// ---- inc/bfc_pkg.sv ----
`default_nettype none
package bfc_pkg;
  // ========================================================
  // one-shot adjust engine states
  typedef enum logic {BFC_ADJ_IDLE, BFC_ADJ_RUN} bfc_adj_e;
  // value field type
  typedef logic [11:0] bfc_val_t;
endpackage : bfc_pkg
`default_nettype wire

// ---- design/bfc_csr.sv ----
`include "bfc_defines.svh"
`default_nettype none
// Summary of operation
// - presence flag reads at position 31
// - abs bit selects absolute value register
// - abs set makes value read-only
// - one-shot write starts adjust, self clears
// - one-shot bit reads one while busy
// - auto mode ignores one-shot requests
// - on/off bit reports feature state
// - feature off makes all fields read-only
// - on/off bit itself is read-only
// - auto/manual bit writable, reads back mode
// - value field positions 0-11, auto ignores writes
// - value in sixteenth units, writes clamped to 0-255
// - value copied to sensor offset 0x9
// - value copied to sensor register 0x09
// - auto adjusts continuously, off holds fixed
// - one-shot ends back in manual, value held
// - value writes only in manual control
// - value field shows setting in effect
module bfc_csr #(
  parameter bit PRESENT = 1'b1,
  parameter bit FEATURE_ON = 1'b1,
  parameter int VALUE_MAX = 255,
  parameter logic [7:0] SENSOR_REG = 8'h09
) (
  input wire logic CLK, // 250 MHz clock
  input wire logic RST_B, // async reset, active low
  input wire logic [`BFC_ADDR_W-1:0] CSR_ADDR, // register byte address
  input wire logic CSR_WR, // write strobe
  input wire logic CSR_RD, // read strobe
  input wire logic [31:0] CSR_WDATA, // write data
  output logic [31:0] CSR_RDATA, // read data
  output logic CSR_ACK, // access done pulse
  input wire logic [11:0] ADJ_TARGET, // level the adjuster seeks
  output logic ABS_SEL, // absolute register controls
  output logic [11:0] VALUE_OUT, // value in effect
  output logic SENSOR_WR, // sensor register write pulse
  output logic [7:0] SENSOR_ADDR, // sensor register address
  output logic [11:0] SENSOR_DATA // sensor register data
);
  // ========================================================
  // parameter checks
  if (VALUE_MAX < 1 || VALUE_MAX > 4095) begin : g_bad_max
    $error("VALUE_MAX out of range");
  end
  localparam int ONE_MAX = `BFC_ONESHOT_CYC + 2;
  localparam bfc_pkg::bfc_val_t VMAX = VALUE_MAX[11:0];

  // ========================================================
  // decode and state
  logic hit; // address matches control word
  logic wr_hit; // write to control word
  logic abs_r; // absolute control bit
  logic am_r; // auto/manual bit
  bfc_pkg::bfc_adj_e adj_r; // one-shot engine state
  bfc_pkg::bfc_val_t value_r; // value field
  bfc_pkg::bfc_val_t prev_val_r; // last value sent to sensor
  logic [11:0] tmo_r; // one-shot cycle counter
  logic busy; // one-shot in progress
  logic manual; // manual control state
  logic adjusting; // adjuster may move the value
  bfc_pkg::bfc_val_t wval; // clamped written value
  bfc_pkg::bfc_val_t step_val; // value one step toward target

  assign hit = (CSR_ADDR == `BFC_CTRL_OFFS);
  assign wr_hit = CSR_WR && hit;
  assign busy = (adj_r == bfc_pkg::BFC_ADJ_RUN);
  assign manual = FEATURE_ON && !am_r && !busy;
  assign adjusting = FEATURE_ON && (am_r || busy);
  assign wval = (CSR_WDATA[`BFC_VAL_HI:`BFC_VAL_LO] > VMAX) ? VMAX :
                CSR_WDATA[`BFC_VAL_HI:`BFC_VAL_LO];
  // one step toward the target level
  always_comb begin
    if (value_r < ADJ_TARGET) begin // move up
      step_val = value_r + 12'h001;
    end else if (value_r > ADJ_TARGET) begin // move down
      step_val = value_r - 12'h001;
    end else begin // settled
      step_val = value_r;
    end
  end

  // ========================================================
  // mode bits
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      abs_r <= `BFC_ABS_RST;
      am_r <= `BFC_AM_RST;
    end else if (wr_hit && FEATURE_ON) begin
      abs_r <= CSR_WDATA[`BFC_ABS_BIT];
      am_r <= CSR_WDATA[`BFC_AM_BIT];
    end
  end

  // ========================================================
  // one-shot engine
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      adj_r <= bfc_pkg::BFC_ADJ_IDLE;
      tmo_r <= 12'h000;
    end else begin
      case (adj_r)
        bfc_pkg::BFC_ADJ_IDLE: begin
          tmo_r <= 12'h000;
          // start one adjust, not in auto
          if (wr_hit && FEATURE_ON && !am_r && CSR_WDATA[`BFC_ONEPUSH_BIT]) begin
            adj_r <= bfc_pkg::BFC_ADJ_RUN;
          end
        end
        bfc_pkg::BFC_ADJ_RUN: begin
          tmo_r <= tmo_r + 12'h001;
          // done on settle or timeout, back to manual
          if (value_r == ADJ_TARGET || tmo_r >= 12'(`BFC_ONESHOT_CYC - 1)) begin
            adj_r <= bfc_pkg::BFC_ADJ_IDLE;
          end
        end
        default: begin // recover
          adj_r <= bfc_pkg::BFC_ADJ_IDLE;
        end
      endcase
    end
  end

  // ========================================================
  // value field
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      value_r <= `BFC_VAL_RST;
    end else if (adjusting) begin
      value_r <= step_val;
    end else if (wr_hit && manual && !abs_r) begin
      value_r <= wval;
    end
  end

  // ========================================================
  // outputs to the datapath and sensor
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      prev_val_r <= `BFC_VAL_RST;
      SENSOR_WR <= 1'b0;
      SENSOR_ADDR <= 8'h00;
      SENSOR_DATA <= 12'h000;
      ABS_SEL <= 1'b0;
      VALUE_OUT <= 12'h000;
    end else begin
      prev_val_r <= value_r;
      ABS_SEL <= abs_r;
      VALUE_OUT <= value_r;
      SENSOR_WR <= (value_r != prev_val_r);
      SENSOR_ADDR <= SENSOR_REG;
      SENSOR_DATA <= value_r;
    end
  end

  // ========================================================
  // read port
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CSR_RDATA <= 32'h0000_0000;
      CSR_ACK <= 1'b0;
    end else begin
      CSR_ACK <= CSR_WR || CSR_RD;
      if (CSR_RD && hit) begin
        CSR_RDATA <= 32'h0000_0000;
        CSR_RDATA[`BFC_PRES_BIT] <= PRESENT;
        CSR_RDATA[`BFC_ABS_BIT] <= abs_r;
        CSR_RDATA[`BFC_ONEPUSH_BIT] <= busy;
        CSR_RDATA[`BFC_ONOFF_BIT] <= FEATURE_ON;
        CSR_RDATA[`BFC_AM_BIT] <= am_r;
        CSR_RDATA[`BFC_VAL_HI:`BFC_VAL_LO] <= value_r;
      end else if (CSR_RD) begin // unmapped reads zero
        CSR_RDATA <= 32'h0000_0000;
      end
    end
  end

  // ========================================================
  // checks
  onepush_end_a: assert property (@(posedge CLK) disable iff (!RST_B)
    $rose(busy) |-> ##[1:ONE_MAX] !busy)
    else $error("one-shot did not self clear");
  auto_ignore_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_hit && am_r && !busy) |=> !busy)
    else $error("one-shot started in auto mode");
  abs_lock_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_hit && abs_r && !adjusting) |=> $stable(value_r))
    else $error("value written under absolute control");
  auto_lock_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_hit && am_r && value_r == ADJ_TARGET && $stable(ADJ_TARGET))
      |=> value_r == $past(value_r))
    else $error("value written in auto mode");
  manual_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_hit && manual && !abs_r) |=> value_r == $past(wval))
    else $error("manual value write lost");
  mode_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_hit && FEATURE_ON) |=> am_r == $past(CSR_WDATA[`BFC_AM_BIT]))
    else $error("mode bit not written");
  read_fields_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (CSR_RD && hit) |=> CSR_RDATA[31] == PRESENT && CSR_RDATA[25] == FEATURE_ON
      && CSR_RDATA[26] == $past(busy))
    else $error("presence or status read wrong");
  reserved_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
    CSR_ACK |-> CSR_RDATA[29:27] == 3'h0 && CSR_RDATA[23:12] == 12'h000)
    else $error("reserved bits not zero");
  sensor_fwd_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (value_r != prev_val_r) |=> SENSOR_WR && SENSOR_DATA == $past(value_r))
    else $error("value not forwarded to sensor");
endmodule : bfc_csr
`default_nettype wire

// ---- testbench/tb_top.sv ----
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus, observed outputs, scoreboard
  logic clk, rst_b, wr, rd, rd_q, ack, swr, abs_sel; // strobes and flags
  logic [11:0] addr, tgt, v1, t, sdata, vout; // address, target, values
  logic [31:0] wdata, rdata, off_rdata; // data words
  logic [7:0] saddr; // sensor register address
  logic [63:0] e; // oldest note: expected and mask
  logic [63:0] exp_q[$]; // notes of expected read words
  int n_mismatch, checked; // counters
  // feature on, checked through the queue
  bfc_csr dut (.CLK(clk), .RST_B(rst_b), .CSR_ADDR(addr), .CSR_WR(wr), .CSR_RD(rd),
    .CSR_WDATA(wdata), .CSR_RDATA(rdata), .CSR_ACK(ack), .ADJ_TARGET(tgt),
    .ABS_SEL(abs_sel), .VALUE_OUT(vout), .SENSOR_WR(swr), .SENSOR_ADDR(saddr),
    .SENSOR_DATA(sdata));
  // feature off, sees the same traffic
  bfc_csr #(.FEATURE_ON(1'b0)) dut_off (.CLK(clk), .RST_B(rst_b), .CSR_ADDR(addr),
    .CSR_WR(wr), .CSR_RD(rd), .CSR_WDATA(wdata), .CSR_RDATA(off_rdata), .CSR_ACK(),
    .ADJ_TARGET(tgt), .ABS_SEL(), .VALUE_OUT(), .SENSOR_WR(), .SENSOR_ADDR(), .SENSOR_DATA());
  // ==========================================================
  // helpers
  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    checked++;
    if (sn !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk
  // expected word from {one-shot, auto, abs} and value
  function automatic logic [31:0] word(input logic [2:0] m, input logic [11:0] v);
    return {1'h1, m[0], 3'h0, m[2], 1'h1, m[1], 12'h000, v};
  endfunction : word
  // write word: random reserved bits, presence and on/off written 0
  function automatic logic [31:0] wd(input logic [2:0] m, input logic [11:0] v);
    return {1'h0, m[0], 3'($urandom), m[2], 1'h0, m[1], 12'($urandom), v};
  endfunction : wd
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m);
    exp_q.push_back({ex & m, m});
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(posedge clk);
  endtask : rd_reg
  // bounded wait for the sensor write pulse
  task automatic sens(input logic [11:0] ex);
    int i;
    for (i = 0; i < 10 && swr !== 1'h1; i++) @(posedge clk);
    if (i == 10) begin
      n_mismatch++;
      $display("CHECK FAILED sensor write expected pulse seen none");
      test_done();
    end else begin
      chk("sensor data", {20'h0, ex}, {20'h0, sdata});
      chk("sensor addr", 32'h9, {24'h0, saddr});
    end
  endtask : sens
  // ==========================================================
  // clock, watchdog, read monitor
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("CHECK FAILED run expected end seen hang");
    test_done();
  end
  always @(posedge clk) begin
    if (ack === 1'h1 && rd_q === 1'h1) begin
      if (exp_q.size() == 0) chk("read note", 32'h0, 32'h1);
      else begin
        e = exp_q.pop_front();
        chk("read data", e[63:32], rdata & e[31:0]);
      end
    end
    rd_q <= rd;
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_b, wr, rd, rd_q, wdata, tgt} = '0;
    addr = 12'h800;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(36489));
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd_reg(12'h800, word(3'h0, 12'h0), '1);
    rd_reg(12'h804, 32'h0, '1);
    v1 = 12'($urandom_range(255, 1));
    wr_reg(12'h800, wd(3'h0, v1));
    sens(v1);
    rd_reg(12'h800, word(3'h0, v1), '1);
    chk("value out", {20'h0, v1}, {20'h0, vout});
    wr_reg(12'h804, wd(3'h0, 12'h0));
    wr_reg(12'h800, wd(3'h0, 12'hfff));
    rd_reg(12'h800, word(3'h0, 12'h0ff), '1);
    wr_reg(12'h800, wd(3'h1, v1));
    @(posedge clk);
    chk("abs select", 32'h1, {31'h0, abs_sel});
    wr_reg(12'h800, wd(3'h1, ~v1));
    rd_reg(12'h800, word(3'h1, v1), '1);
    wr_reg(12'h800, wd(3'h0, v1));
    t = 12'($urandom_range(255));
    tgt <= t;
    wr_reg(12'h800, wd(3'h2, v1));
    wr_reg(12'h800, wd(3'h6, 12'h010));
    repeat (300) @(posedge clk);
    rd_reg(12'h800, word(3'h2, t), '1);
    wr_reg(12'h800, wd(3'h0, t));
    tgt <= t ^ 12'h080;
    wr_reg(12'h800, wd(3'h4, t));
    rd_reg(12'h800, word(3'h4, 12'h0), 32'hffff_f000);
    repeat (300) @(posedge clk);
    rd_reg(12'h800, word(3'h0, t ^ 12'h080), '1);
    // one-shot cut by its 500-cycle limit, one code per cycle
    tgt <= 12'hfff;
    wr_reg(12'h800, wd(3'h4, 12'h010));
    repeat (600) @(posedge clk);
    rd_reg(12'h800, word(3'h0, 12'h204), '1);
    chk("off word", 32'h8000_0000, off_rdata);
    @(posedge clk);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
